// ---- verilog/mpcs_params.svh ----
// Constants for the multipurpose port with chip-select decode
`ifndef MPCS_PARAMS_SVH
`define MPCS_PARAMS_SVH

// ---------------------------------------------------------------
// Special function register addresses
// ---------------------------------------------------------------
`define MPCS_OFS_PIN0_BASE_LO   8'h84
`define MPCS_OFS_PIN0_BASE_HI   8'h85
`define MPCS_OFS_PORT_OPTIONS   8'h86
`define MPCS_OFS_PIN1_BASE_LO   8'h94
`define MPCS_OFS_PIN1_BASE_HI   8'h95
`define MPCS_OFS_PIN2_BASE_LO   8'hac
`define MPCS_OFS_PIN2_BASE_HI   8'had
`define MPCS_OFS_POLARITY       8'hae
`define MPCS_OFS_PIN3_BASE_LO   8'hb4
`define MPCS_OFS_PIN3_BASE_HI   8'hb5
`define MPCS_OFS_FUNC_CTRL_LO   8'hc2
`define MPCS_OFS_FUNC_CTRL_HI   8'hc3
`define MPCS_OFS_PORT_LATCH     8'hd8
// Bit addresses of the latch share the upper five bits of its byte address
`define MPCS_BIT_BLOCK          5'h1b

// ---------------------------------------------------------------
// Reset values and field positions
// ---------------------------------------------------------------
`define MPCS_LATCH_RESET        8'hff
`define MPCS_REG_RESET          8'h00
`define MPCS_POL_LSB            4
`define MPCS_HD_LSB             4
`define MPCS_PULLUP_BIT         0
`define MPCS_IRQ_PIN_A          2
`define MPCS_IRQ_PIN_B          3
`define MPCS_RD_DATA_NONE       8'h00
`define MPCS_FLD_FN_UPPER       7:6
`define MPCS_FLD_CMP_UPPER      5:4
`define MPCS_FLD_FN_LOWER       3:2
`define MPCS_FLD_CMP_LOWER      1:0

// ---------------------------------------------------------------
// Compare masks and reset filter
// ---------------------------------------------------------------
`define MPCS_MASK_FULL          16'hffff
`define MPCS_MASK_A1            16'hfffe
`define MPCS_MASK_A2            16'hfffc
`define MPCS_MASK_A8            16'hff00
`define MPCS_RST_SAMPLES        2

`endif

// ---- verilog/mpcs_pkg.sv ----
// Types shared by the multipurpose port design files
`default_nettype none

package mpcs_pkg;

  typedef enum logic [1:0] {
    MPCS_FN_GPIO  = 2'h0,
    MPCS_FN_RD    = 2'h1,
    MPCS_FN_WR    = 2'h2,
    MPCS_FN_RW    = 2'h3
  } mpcs_func_type;

  typedef enum logic [1:0] {
    MPCS_CMP_FULL = 2'h0,
    MPCS_CMP_A1   = 2'h1,
    MPCS_CMP_A2   = 2'h2,
    MPCS_CMP_A8   = 2'h3
  } mpcs_cmp_type;

  // Reset pin filter, Gray coded along idle -> one -> held
  typedef enum logic [1:0] {
    MPCS_RS_IDLE  = 2'h0,
    MPCS_RS_ONE   = 2'h1,
    MPCS_RS_HELD  = 2'h3
  } mpcs_rst_state_type;

endpackage

`default_nettype wire

// ---- verilog/mpcs_sync2.sv ----
// Two-stage synchroniser for pin levels
`default_nettype none

module mpcs_sync2 #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RESET_VAL = 8'hff
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= RESET_VAL[WIDTH-1:0];
      q_o    <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/mpcs_addr_match.sv ----
// Base address comparator for one chip-select pin
`default_nettype none
`include "mpcs_params.svh"

module mpcs_addr_match
  import mpcs_pkg::*;
(
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] base_i,
  input  wire logic [1:0]  cmp_len_i,
  output var  logic        match_o
);

  logic [15:0] mask;

  always_comb begin
    case (cmp_len_i)
      MPCS_CMP_FULL: mask = `MPCS_MASK_FULL;
      MPCS_CMP_A1:   mask = `MPCS_MASK_A1;
      MPCS_CMP_A2:   mask = `MPCS_MASK_A2;
      MPCS_CMP_A8:   mask = `MPCS_MASK_A8;
      default:       mask = `MPCS_MASK_FULL;
    endcase
    match_o = ((addr_i ^ base_i) & mask) == 16'h0000;
  end

endmodule

`default_nettype wire

// ---- verilog/mpcs_port.sv ----
// Multipurpose port: quasi-bidirectional I/O and decoded chip-select strobes
//
// Notes on behaviour
// - Port latch is a special function register; each pin configured on its own.
// - General setting: low four pins act as quasi-bidirectional I/O.
// - General setting: pins 2 and 3 feed external interrupts when enabled.
// - Read strobe setting: pin pulses with read strobe on matching address.
// - Write strobe setting: pin pulses with write strobe on matching address.
// - Read/write setting: pin pulses with either strobe on matching address.
// - Each of pins 0 to 3 has high and low base bytes forming a 16-bit base.
// - Two function control registers choose the setting of each of pins 0 to 3.
// - Options register holds high-drive enables for pins 4 to 7.
// - Port 0 open drain unless its pull-up option bit is set.
// - Reset loads the port latch with all ones.
// - Reset clears configuration, base, polarity and option registers.
// - Reset pin sampled once per machine cycle; needs two high samples.
// - Latch writable as a byte and as single addressed bits.
// - Function field: 00 I/O, 01 read, 10 write, 11 read/write.
// - Compare length: bits 15..0, 15..1, 15..2 or 15..8.
// - Polarity bit set gives active-high strobe, clear gives active low.
// - High control register holds pins 3 and 2; low holds pins 1 and 0.
`default_nettype none
`include "mpcs_params.svh"

module mpcs_port
  import mpcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output var  logic [7:0]  sfr_rdata_o,
  output var  logic        sfr_hit_o,
  input  wire logic [7:0]  bit_addr_i,
  input  wire logic        bit_wr_i,
  input  wire logic        bit_wdata_i,
  output var  logic        bit_rdata_o,
  input  wire logic [15:0] ext_addr_i,
  input  wire logic        ext_rd_i,
  input  wire logic        ext_wr_i,
  input  wire logic [1:0]  irq_en_i,
  input  wire logic [7:0]  pin_in_i,
  output var  logic [7:0]  pin_out_o,
  output var  logic [7:0]  pin_oe_o,
  output var  logic [3:0]  high_drive_enable_o,
  output var  logic        port0_pullup_enable_o,
  output var  logic        ext_irq_two_n_o,
  output var  logic        ext_irq_three_n_o,
  input  wire logic        rst_pin_i,
  input  wire logic        state5_phase2_i,
  output var  logic        sys_reset_o
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  localparam logic [7:0] BASE_LO_OFS [4] = '{`MPCS_OFS_PIN0_BASE_LO, `MPCS_OFS_PIN1_BASE_LO,
                                             `MPCS_OFS_PIN2_BASE_LO, `MPCS_OFS_PIN3_BASE_LO};
  localparam logic [7:0] BASE_HI_OFS [4] = '{`MPCS_OFS_PIN0_BASE_HI, `MPCS_OFS_PIN1_BASE_HI,
                                             `MPCS_OFS_PIN2_BASE_HI, `MPCS_OFS_PIN3_BASE_HI};

  logic [7:0]         latch_q;
  logic [7:0]         base_lo_q [4];
  logic [7:0]         base_hi_q [4];
  logic [7:0]         polarity_q;
  logic [7:0]         options_q;
  logic [7:0]         ctrl_lo_q;
  logic [7:0]         ctrl_hi_q;
  logic [7:0]         pin_sync;
  logic               rst_sync;
  logic               soft_rst;
  logic [3:0]         match;
  logic [3:0]         cs_active;
  logic [1:0]         pin_func [4];
  logic [1:0]         pin_cmp [4];
  logic [7:0]         rdata_d;
  logic               hit_d;
  logic               bit_hit;
  mpcs_rst_state_type rst_state_q;

  // ---------------------------------------------------------------
  // Pin and reset synchronisers
  // ---------------------------------------------------------------
  mpcs_sync2 #(
    .WIDTH     (8),
    .RESET_VAL (`MPCS_LATCH_RESET)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (pin_in_i),
    .q_o     (pin_sync)
  );

  mpcs_sync2 #(
    .WIDTH     (1),
    .RESET_VAL (`MPCS_REG_RESET)
  ) u_rst_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (rst_pin_i),
    .q_o     (rst_sync)
  );

  // ---------------------------------------------------------------
  // Reset pin filter
  // ---------------------------------------------------------------
  // Sampling only at the phase strobe rejects glitches shorter than a machine cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_state_q <= MPCS_RS_IDLE;
    end else if (state5_phase2_i) begin
      case (rst_state_q)
        MPCS_RS_IDLE: rst_state_q <= rst_sync ? MPCS_RS_ONE : MPCS_RS_IDLE;
        MPCS_RS_ONE:  rst_state_q <= rst_sync ? MPCS_RS_HELD : MPCS_RS_IDLE;
        MPCS_RS_HELD: rst_state_q <= rst_sync ? MPCS_RS_HELD : MPCS_RS_IDLE;
        default:      rst_state_q <= MPCS_RS_IDLE;
      endcase
    end
  end

  assign soft_rst = (rst_state_q == MPCS_RS_HELD);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= soft_rst;
    end
  end

  // ---------------------------------------------------------------
  // Port latch: byte and bit writes
  // ---------------------------------------------------------------
  assign bit_hit = (bit_addr_i[7:3] == `MPCS_BIT_BLOCK);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_q <= `MPCS_LATCH_RESET;
    end else if (soft_rst) begin
      latch_q <= `MPCS_LATCH_RESET;
    end else if (sfr_wr_i && sfr_addr_i == `MPCS_OFS_PORT_LATCH) begin
      latch_q <= sfr_wdata_i;
    end else if (bit_wr_i && bit_hit) begin
      latch_q[bit_addr_i[2:0]] <= bit_wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_lo_q  <= `MPCS_REG_RESET;
      ctrl_hi_q  <= `MPCS_REG_RESET;
      polarity_q <= `MPCS_REG_RESET;
      options_q  <= `MPCS_REG_RESET;
    end else if (soft_rst) begin
      ctrl_lo_q  <= `MPCS_REG_RESET;
      ctrl_hi_q  <= `MPCS_REG_RESET;
      polarity_q <= `MPCS_REG_RESET;
      options_q  <= `MPCS_REG_RESET;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        `MPCS_OFS_FUNC_CTRL_LO: ctrl_lo_q  <= sfr_wdata_i;
        `MPCS_OFS_FUNC_CTRL_HI: ctrl_hi_q  <= sfr_wdata_i;
        `MPCS_OFS_POLARITY:     polarity_q <= sfr_wdata_i;
        `MPCS_OFS_PORT_OPTIONS: options_q  <= sfr_wdata_i;
        default:                ctrl_lo_q  <= ctrl_lo_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-pin base registers, decode and strobes
  // ---------------------------------------------------------------
  // Pin 3 sits in the top of the high register, pin 0 in the bottom of the low
  assign pin_func[3] = ctrl_hi_q[`MPCS_FLD_FN_UPPER];
  assign pin_cmp[3]  = ctrl_hi_q[`MPCS_FLD_CMP_UPPER];
  assign pin_func[2] = ctrl_hi_q[`MPCS_FLD_FN_LOWER];
  assign pin_cmp[2]  = ctrl_hi_q[`MPCS_FLD_CMP_LOWER];
  assign pin_func[1] = ctrl_lo_q[`MPCS_FLD_FN_UPPER];
  assign pin_cmp[1]  = ctrl_lo_q[`MPCS_FLD_CMP_UPPER];
  assign pin_func[0] = ctrl_lo_q[`MPCS_FLD_FN_LOWER];
  assign pin_cmp[0]  = ctrl_lo_q[`MPCS_FLD_CMP_LOWER];

  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        base_lo_q[i] <= `MPCS_REG_RESET;
        base_hi_q[i] <= `MPCS_REG_RESET;
      end else if (soft_rst) begin
        base_lo_q[i] <= `MPCS_REG_RESET;
        base_hi_q[i] <= `MPCS_REG_RESET;
      end else if (sfr_wr_i && sfr_addr_i == BASE_LO_OFS[i]) begin
        base_lo_q[i] <= sfr_wdata_i;
      end else if (sfr_wr_i && sfr_addr_i == BASE_HI_OFS[i]) begin
        base_hi_q[i] <= sfr_wdata_i;
      end
    end

    mpcs_addr_match u_match (
      .addr_i    (ext_addr_i),
      .base_i    ({base_hi_q[i], base_lo_q[i]}),
      .cmp_len_i (pin_cmp[i]),
      .match_o   (match[i])
    );

    // Strobe inputs are the core's next-cycle values, so the registered pin
    // changes on the same edge as the core's own strobe pin
    always_comb begin
      case (pin_func[i])
        MPCS_FN_RD: cs_active[i] = ext_rd_i && match[i];
        MPCS_FN_WR: cs_active[i] = ext_wr_i && match[i];
        MPCS_FN_RW: cs_active[i] = (ext_rd_i || ext_wr_i) && match[i];
        default:    cs_active[i] = 1'b0;
      endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        pin_out_o[i] <= 1'b1;
        pin_oe_o[i]  <= 1'b0;
      end else if (pin_func[i] == MPCS_FN_GPIO) begin
        pin_out_o[i] <= latch_q[i];
        pin_oe_o[i]  <= ~latch_q[i];
      end else begin
        // Inactive level whenever no qualified match; latch never reaches the pin
        pin_out_o[i] <= cs_active[i] ~^ polarity_q[`MPCS_POL_LSB + i];
        pin_oe_o[i]  <= 1'b1;
      end
    end
  end

  // Upper nibble is plain quasi-bidirectional I/O; drive strength is separate
  for (genvar j = 4; j < 8; j++) begin : g_upper
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        pin_out_o[j] <= 1'b1;
        pin_oe_o[j]  <= 1'b0;
      end else begin
        pin_out_o[j] <= latch_q[j];
        pin_oe_o[j]  <= ~latch_q[j];
      end
    end
  end

  // ---------------------------------------------------------------
  // Options and interrupt outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_drive_enable_o   <= 4'h0;
      port0_pullup_enable_o <= 1'b0;
      ext_irq_two_n_o       <= 1'b1;
      ext_irq_three_n_o     <= 1'b1;
    end else begin
      high_drive_enable_o   <= options_q[`MPCS_HD_LSB +: 4];
      port0_pullup_enable_o <= options_q[`MPCS_PULLUP_BIT];
      // Held inactive while the pin is a strobe, so our own pulses never interrupt
      ext_irq_two_n_o   <= (irq_en_i[0] && pin_func[`MPCS_IRQ_PIN_A] == MPCS_FN_GPIO) ?
                           pin_sync[`MPCS_IRQ_PIN_A] : 1'b1;
      ext_irq_three_n_o <= (irq_en_i[1] && pin_func[`MPCS_IRQ_PIN_B] == MPCS_FN_GPIO) ?
                           pin_sync[`MPCS_IRQ_PIN_B] : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = `MPCS_RD_DATA_NONE;
    hit_d   = 1'b1;
    case (sfr_addr_i)
      `MPCS_OFS_PORT_LATCH:   rdata_d = pin_sync;
      `MPCS_OFS_FUNC_CTRL_LO: rdata_d = ctrl_lo_q;
      `MPCS_OFS_FUNC_CTRL_HI: rdata_d = ctrl_hi_q;
      `MPCS_OFS_POLARITY:     rdata_d = polarity_q;
      `MPCS_OFS_PORT_OPTIONS: rdata_d = options_q;
      `MPCS_OFS_PIN0_BASE_LO: rdata_d = base_lo_q[0];
      `MPCS_OFS_PIN0_BASE_HI: rdata_d = base_hi_q[0];
      `MPCS_OFS_PIN1_BASE_LO: rdata_d = base_lo_q[1];
      `MPCS_OFS_PIN1_BASE_HI: rdata_d = base_hi_q[1];
      `MPCS_OFS_PIN2_BASE_LO: rdata_d = base_lo_q[2];
      `MPCS_OFS_PIN2_BASE_HI: rdata_d = base_hi_q[2];
      `MPCS_OFS_PIN3_BASE_LO: rdata_d = base_lo_q[3];
      `MPCS_OFS_PIN3_BASE_HI: rdata_d = base_hi_q[3];
      default:                hit_d   = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sfr_rdata_o <= `MPCS_RD_DATA_NONE;
      sfr_hit_o   <= 1'b0;
      bit_rdata_o <= 1'b0;
    end else begin
      sfr_rdata_o <= sfr_rd_i ? rdata_d : `MPCS_RD_DATA_NONE;
      sfr_hit_o   <= sfr_rd_i && hit_d;
      bit_rdata_o <= bit_hit && pin_sync[bit_addr_i[2:0]];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_soft_reset_latch: assert property (soft_rst |=> latch_q == `MPCS_LATCH_RESET)
    else $error("latch not all ones after reset pin");
  a_soft_reset_cfg: assert property (soft_rst |=> (ctrl_lo_q | ctrl_hi_q | options_q) == 8'h00)
    else $error("configuration not cleared after reset pin");
  a_reset_two_samples: assert property (
    (state5_phase2_i && !rst_sync && rst_state_q != MPCS_RS_HELD) |=> !soft_rst)
    else $error("reset taken without two high samples");
  a_bit_write: assert property (
    (bit_wr_i && bit_hit && !soft_rst && !sfr_wr_i) |=>
    latch_q[$past(bit_addr_i[2:0])] == $past(bit_wdata_i))
    else $error("bit write did not reach the latch");
  a_high_drive: assert property (
    (sfr_wr_i && sfr_addr_i == `MPCS_OFS_PORT_OPTIONS && !soft_rst) |=>
    ##1 high_drive_enable_o == $past(sfr_wdata_i[`MPCS_HD_LSB +: 4], 2))
    else $error("high drive enables do not follow options write");
  a_irq_pass: assert property (
    (irq_en_i[0] && pin_func[`MPCS_IRQ_PIN_A] == MPCS_FN_GPIO) |=>
    ext_irq_two_n_o == $past(pin_sync[`MPCS_IRQ_PIN_A]))
    else $error("interrupt input not passed from pin 2");

  for (genvar k = 0; k < 4; k++) begin : g_chk
    a_cs_rd_pulse: assert property (
      (pin_func[k] == MPCS_FN_RD && ext_rd_i && match[k]) |=>
      pin_out_o[k] == $past(polarity_q[`MPCS_POL_LSB + k]))
      else $error("read chip select missing");
    a_cs_wr_pulse: assert property (
      (pin_func[k] == MPCS_FN_WR && ext_wr_i && match[k]) |=>
      pin_out_o[k] == $past(polarity_q[`MPCS_POL_LSB + k]))
      else $error("write chip select missing");
    a_cs_idle_level: assert property (
      (pin_func[k] != MPCS_FN_GPIO && !(ext_rd_i || ext_wr_i)) |=>
      (pin_out_o[k] != $past(polarity_q[`MPCS_POL_LSB + k])) && pin_oe_o[k])
      else $error("strobe pin not at inactive level");
    a_gpio_drive: assert property (
      (pin_func[k] == MPCS_FN_GPIO) |=> pin_oe_o[k] == !$past(latch_q[k]))
      else $error("general pin drive does not follow latch");
  end

  c_rd_strobe: cover property (pin_func[0] == MPCS_FN_RD && ext_rd_i && match[0]);
  c_rw_strobe: cover property (pin_func[3] == MPCS_FN_RW && ext_wr_i && match[3]);
  c_soft_reset: cover property (soft_rst);

endmodule

`default_nettype wire

// ---- verif/mpcs_periph_model.sv ----
// Peripheral side model: pad resolution and chip-select view of the port pins
`default_nettype none

module mpcs_periph_model (
  input  wire logic [7:0] pin_out_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pull_low_i,
  input  wire logic [3:0] polarity_i,
  output var  logic [7:0] pad_o,
  output var  logic [3:0] sel_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Pads and selects
  // ------------------------------------------------------------
  // Weak pull-up wins unless the port or a peripheral sinks the line
  assign pad_o = ~((pin_oe_i & ~pin_out_i) | pull_low_i);
  // A peripheral counts as selected while its pad sits at the active level
  assign sel_o = ~(pad_o[3:0] ^ polarity_i);
endmodule

`default_nettype wire

// ---- verif/mpcs_port_test.sv ----
// Self-checking bench for the multipurpose port
`default_nettype none
`include "mpcs_params.svh"

module mpcs_port_test
  import mpcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        state5_phase2_i = 1'b0;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i, pin_in_i, pin_out_o, pin_oe_o;
  logic [7:0]  pull_low;
  logic [15:0] ext_addr_i;
  logic [3:0]  high_drive_enable_o, sel;
  logic [3:0]  polarity = 4'h0;
  logic [1:0]  irq_en_i;
  logic        sfr_wr_i, sfr_rd_i, sfr_hit_o, bit_wr_i, bit_wdata_i, bit_rdata_o, ext_rd_i;
  logic        ext_wr_i, port0_pullup_enable_o, ext_irq_two_n_o, ext_irq_three_n_o;
  logic        rst_pin_i, sys_reset_o;
  int          err_count = 0, num_checks = 0, cycles = 0;
  localparam logic [7:0] reg_ofs [12] = '{`MPCS_OFS_PIN0_BASE_LO, `MPCS_OFS_PIN0_BASE_HI,
    `MPCS_OFS_PIN1_BASE_LO, `MPCS_OFS_PIN1_BASE_HI, `MPCS_OFS_PIN2_BASE_LO,
    `MPCS_OFS_PIN2_BASE_HI, `MPCS_OFS_PIN3_BASE_LO, `MPCS_OFS_PIN3_BASE_HI,
    `MPCS_OFS_POLARITY, `MPCS_OFS_PORT_OPTIONS, `MPCS_OFS_FUNC_CTRL_LO, `MPCS_OFS_FUNC_CTRL_HI};

  mpcs_port mpcs_port_i (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .bit_addr_i(bit_addr_i),
    .bit_wr_i(bit_wr_i), .bit_wdata_i(bit_wdata_i), .bit_rdata_o(bit_rdata_o),
    .ext_addr_i(ext_addr_i), .ext_rd_i(ext_rd_i), .ext_wr_i(ext_wr_i), .irq_en_i(irq_en_i),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .high_drive_enable_o(high_drive_enable_o), .port0_pullup_enable_o(port0_pullup_enable_o),
    .ext_irq_two_n_o(ext_irq_two_n_o), .ext_irq_three_n_o(ext_irq_three_n_o),
    .rst_pin_i(rst_pin_i), .state5_phase2_i(state5_phase2_i), .sys_reset_o(sys_reset_o));

  mpcs_periph_model mpcs_periph_model_i (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
    .pull_low_i(pull_low), .polarity_i(polarity), .pad_o(pin_in_i), .sel_o(sel));

  // ------------------------------------------------------------
  // Clock, machine-cycle phase and watchdog
  // ------------------------------------------------------------
  always #2 clk_i = ~clk_i;
  // One sampling phase every twelve core clocks
  always @(negedge clk_i) state5_phase2_i <= (cycles % 12 == 11);
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  function automatic logic [15:0] base(input int k);
    return {4'(k + 1), 12'h234};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    tick(1);
    sfr_wr_i = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    tick(1);
    sfr_rd_i = 1'b0;
    check("read data", 16'(sfr_rdata_o), 16'(e));
    check("read hit", 16'(sfr_hit_o), 16'(h));
    tick(1);
    check("read idle", 16'(sfr_rdata_o), 16'h0);
  endtask

  task automatic acc(input logic [15:0] a, input logic r, input logic w, input logic [3:0] e);
    ext_addr_i = a;
    ext_rd_i = r;
    ext_wr_i = w;
    tick(1);
    check("selected", 16'(sel), 16'(e));
    ext_rd_i = 1'b0;
    ext_wr_i = 1'b0;
    tick(1);
    check("released", 16'(sel), 16'h0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("latch out", 16'(pin_out_o), 16'h00ff);
    check("latch oe", 16'(pin_oe_o), 16'h0000);
    check("options", {11'h0, high_drive_enable_o, port0_pullup_enable_o}, 16'h0);
    check("sys reset", 16'(sys_reset_o), 16'h0);
    foreach (reg_ofs[i]) rd(reg_ofs[i], 8'h00, 1'b1);
    rd(8'h80, 8'h00, 1'b0);
  endtask

  task automatic t_regs();
    foreach (reg_ofs[i]) wr(reg_ofs[i], 8'h5a ^ 8'(i));
    foreach (reg_ofs[i]) rd(reg_ofs[i], 8'h5a ^ 8'(i), 1'b1);
    foreach (reg_ofs[i]) wr(reg_ofs[i], 8'h00);
    wr(`MPCS_OFS_PORT_OPTIONS, 8'ha1);
    check("high drive", 16'(high_drive_enable_o), 16'h000a);
    check("pull-up", 16'(port0_pullup_enable_o), 16'h0001);
    wr(`MPCS_OFS_PORT_OPTIONS, 8'h50);
    check("high drive", 16'(high_drive_enable_o), 16'h0005);
    check("pull-up", 16'(port0_pullup_enable_o), 16'h0000);
  endtask

  task automatic t_gpio();
    wr(`MPCS_OFS_PORT_LATCH, 8'h5a);
    check("latch out", 16'(pin_out_o), 16'h005a);
    check("latch oe", 16'(pin_oe_o), 16'h00a5);
    pull_low = 8'h02;
    tick(3);
    rd(`MPCS_OFS_PORT_LATCH, 8'h58, 1'b1);
    bit_addr_i = {`MPCS_BIT_BLOCK, 3'h0};
    bit_wdata_i = 1'b1;
    bit_wr_i = 1'b1;
    tick(1);
    bit_wr_i = 1'b0;
    bit_addr_i = {`MPCS_BIT_BLOCK, 3'h1};
    tick(1);
    check("bit write", 16'(pin_out_o), 16'h005b);
    check("bit read", 16'(bit_rdata_o), 16'h0);
    bit_addr_i = {`MPCS_BIT_BLOCK, 3'h3};
    tick(1);
    check("bit read", 16'(bit_rdata_o), 16'h1);
    pull_low = 8'h00;
    wr(`MPCS_OFS_PORT_LATCH, 8'hff);
  endtask

  task automatic t_irq();
    irq_en_i = 2'b01;
    pull_low = 8'h0c;
    tick(3);
    check("irq two", 16'(ext_irq_two_n_o), 16'h0);
    check("irq three", 16'(ext_irq_three_n_o), 16'h1);
    irq_en_i = 2'b10;
    // Pin three as read strobe must stop feeding its interrupt
    wr(`MPCS_OFS_FUNC_CTRL_HI, 8'h40);
    tick(2);
    check("irq two", 16'(ext_irq_two_n_o), 16'h1);
    check("irq three", 16'(ext_irq_three_n_o), 16'h1);
    wr(`MPCS_OFS_FUNC_CTRL_HI, 8'h00);
    tick(2);
    check("irq three", 16'(ext_irq_three_n_o), 16'h0);
    pull_low = 8'h00;
    irq_en_i = 2'b00;
  endtask

  task automatic t_strobe();
    logic [7:0] fn;
    for (int k = 0; k < 4; k++) begin
      wr(reg_ofs[2*k], 8'h34);
      wr(reg_ofs[2*k+1], {4'(k + 1), 4'h2});
    end
    for (int p = 0; p < 2; p++) begin
      polarity = p ? 4'hf : 4'h0;
      wr(`MPCS_OFS_POLARITY, {polarity, 4'h0});
      for (int f = 1; f < 4; f++) begin
        fn = {2'(f), 2'h0, 2'(f), 2'h0};
        wr(`MPCS_OFS_FUNC_CTRL_LO, fn);
        wr(`MPCS_OFS_FUNC_CTRL_HI, fn);
        for (int k = 0; k < 4; k++) begin
          acc(base(k), 1'b1, 1'b0, f[0] ? 4'(1 << k) : 4'h0);
          acc(base(k), 1'b0, 1'b1, f[1] ? 4'(1 << k) : 4'h0);
          acc(base(k) ^ 16'h0001, 1'b1, 1'b0, 4'h0);
        end
      end
    end
  endtask

  task automatic t_cmp();
    logic [15:0] ign [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h00ff};
    for (int c = 0; c < 4; c++) begin
      wr(`MPCS_OFS_FUNC_CTRL_LO, {MPCS_FN_RW, 2'(c), MPCS_FN_RW, 2'(c)});
      wr(`MPCS_OFS_FUNC_CTRL_HI, {MPCS_FN_RW, 2'(c), MPCS_FN_RW, 2'(c)});
      for (int k = 0; k < 4; k++) begin
        acc(base(k) ^ ign[c], 1'b0, 1'b1, 4'(1 << k));
        acc(base(k) ^ (ign[c] + 16'h1), 1'b0, 1'b1, 4'h0);
      end
    end
  endtask

  task automatic t_rstpin();
    wr(`MPCS_OFS_POLARITY, 8'h50);
    for (int i = 0; i < 12 && state5_phase2_i !== 1'b1; i++) tick(1);
    // Long enough for a single sample only, so no reset may follow
    rst_pin_i = 1'b1;
    tick(14);
    rst_pin_i = 1'b0;
    tick(24);
    check("sys reset", 16'(sys_reset_o), 16'h0);
    rd(`MPCS_OFS_POLARITY, 8'h50, 1'b1);
    rst_pin_i = 1'b1;
    tick(40);
    check("sys reset", 16'(sys_reset_o), 16'h1);
    check("latch out", 16'(pin_out_o), 16'h00ff);
    wr(`MPCS_OFS_POLARITY, 8'h30);
    rd(`MPCS_OFS_POLARITY, 8'h00, 1'b1);
    rst_pin_i = 1'b0;
    tick(30);
    check("sys reset", 16'(sys_reset_o), 16'h0);
  endtask

  initial begin
    {sfr_addr_i, sfr_wdata_i, bit_addr_i, pull_low, ext_addr_i} = '0;
    {sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i, ext_rd_i, ext_wr_i, rst_pin_i} = '0;
    irq_en_i = 2'b00;
    repeat (3) @(posedge clk_i);
    tick(1);
    reset_i = 1'b0;
    tick(1);
    t_reset();
    t_regs();
    t_gpio();
    t_irq();
    t_strobe();
    t_cmp();
    t_rstpin();
    end_of_test();
  end
endmodule

`default_nettype wire
